/* clif_checker.sv */
// Port checks for the instruction front end
`timescale 1ns/1ps
module clif_checker
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [6:0] display_shift_q,
  input wire display_on_q,
  input wire cursor_on_q,
  input wire blink_on_q
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire rd = acc && !pwrite;
  wire ir = paddr == 12'h000;
  wire map = ir || paddr == 12'h004 || paddr == 12'h008;
  chk_ready_high: assert property (pready) else $error("pready low");
  chk_err_unmapped: assert property (acc && !map |-> pslverr) else $error("no error on unmapped");
  chk_err_mapped: assert property (acc && map |-> !pslverr) else $error("error on mapped");
  chk_rdata_idle: assert property (!rd |-> prdata == 32'h0) else $error("read data outside read");
  chk_status_upper: assert property (rd && paddr == 12'h008 |-> prdata[31:2] == 30'h0) else $error("status bits");
  chk_ir_upper: assert property (rd && ir |-> prdata[31:8] == 24'h0) else $error("busy read width");
  chk_busy_after_write: assert property (acc && pwrite && ir ##3 rd && ir |-> prdata[7])
    else $error("not busy after instruction");
  chk_reset_zero: assert property ($rose(presetn) |-> display_shift_q == 7'h00 && !display_on_q
    && !cursor_on_q && !blink_on_q) else $error("outputs not cleared by reset");
  chk_disp_hold: assert property (!(acc && pwrite && ir) |=> $stable({display_on_q, cursor_on_q, blink_on_q}))
    else $error("display control changed without instruction");
  cover property (rd && ir && prdata[7]);
  cover property (rd && paddr == 12'h008 && prdata[1]);
  cover property (acc && !map);
  cover property ($changed(display_shift_q));
endmodule // clif_checker

/* clif_defs.vh */
// Constants for the character display instruction front end
`ifndef CLIF_DEFS_VH
`define CLIF_DEFS_VH
`define CLIF_CLK_KHZ 10000
`define CLIF_CLK_NS 100
`define CLIF_T_SHORT_NS 40000
`define CLIF_T_HOME_NS 1600000
`define CLIF_T_CLEAR_NS 1640000
`define CLIF_T_ADD_NS 1000
`define CLIF_CYC_SHORT ((`CLIF_T_SHORT_NS + `CLIF_CLK_NS - 1) / `CLIF_CLK_NS)
`define CLIF_CYC_HOME ((`CLIF_T_HOME_NS + `CLIF_CLK_NS - 1) / `CLIF_CLK_NS)
`define CLIF_CYC_CLEAR ((`CLIF_T_CLEAR_NS + `CLIF_CLK_NS - 1) / `CLIF_CLK_NS)
`define CLIF_CYC_ADD ((`CLIF_T_ADD_NS + `CLIF_CLK_NS - 1) / `CLIF_CLK_NS)
`define CLIF_BIT_CLEAR 0
`define CLIF_BIT_HOME 1
`define CLIF_BIT_ENTRY 2
`define CLIF_BIT_DISP 3
`define CLIF_BIT_SHIFT 4
`define CLIF_BIT_FUNC 5
`define CLIF_BIT_CGADR 6
`define CLIF_BIT_DDADR 7
`define CLIF_SPACE_CODE 8'h20
`define CLIF_DD_SIZE 128
`define CLIF_CG_SIZE 64
`define CLIF_RST_ENTRY_INC 1'b1
`define CLIF_RST_ENTRY_SHIFT 1'b0
`define CLIF_DIV_1US ((1000 + `CLIF_CLK_NS - 1) / `CLIF_CLK_NS)
`endif

/* clif_frontend.v */
// Instruction front end with APB register access
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
`include "clif_defs.vh"
module clif_frontend
#(
  parameter CYC_CLEAR = `CLIF_CYC_CLEAR,
  parameter CYC_HOME = `CLIF_CYC_HOME,
  parameter CYC_SHORT = `CLIF_CYC_SHORT
)
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output reg [6:0] display_shift_q,
  output reg display_on_q,
  output reg cursor_on_q,
  output reg blink_on_q
);
  // Byte addresses: each register is selected by a compare of the whole 12-bit paddr
  localparam [11:0] ADDR_INSTR = 12'h000;
  localparam [11:0] ADDR_DATA = 12'h004;
  localparam [11:0] ADDR_STAT = 12'h008;
  localparam [20:0] CYC_CLEAR_W = CYC_CLEAR[20:0];
  localparam [20:0] CYC_HOME_W = CYC_HOME[20:0];
  localparam [20:0] CYC_SHORT_W = CYC_SHORT[20:0];
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_EXEC = 2'b01;
  localparam [1:0] ST_CLEAR = 2'b10;
  localparam [1:0] ST_ADD = 2'b11;

  reg [7:0] dd_mem [0:`CLIF_DD_SIZE-1];
  reg [7:0] cg_mem [0:`CLIF_CG_SIZE-1];
  reg [1:0] state_q;
  reg [6:0] addr_q;
  reg cg_sel_q;
  reg inc_q;
  reg shift_q;
  reg pend_step_q;
  reg pend_shift_q;
  reg refused_q;
  reg [6:0] clr_idx_q;
  reg [20:0] tcyc;
  reg tstart;
  reg [3:0] cmd;
  wire busy_flag;
  wire acc;
  wire wr_acc;
  wire rd_acc;
  wire is_instr;
  wire is_data;
  wire is_stat;
  wire mapped;
  wire launch_ok;
  wire refuse_now;
  wire dd_we;
  wire cg_we;

  // Highest set data bit selects the instruction
  function [3:0] clif_decode;
    input [7:0] b;
    integer i;
    begin
      clif_decode = 4'hF;
      for (i = 0; i < 8; i = i + 1)
        if (b[i])
          clif_decode = i[3:0];
    end
  endfunction

  // Address counter step, wrapped to the active RAM
  function [6:0] clif_step;
    input [6:0] a;
    input up;
    input cg;
    reg [6:0] n;
    begin
      n = up ? a + 7'h01 : a - 7'h01;
      clif_step = cg ? {1'b0, n[5:0]} : n;
    end
  endfunction

  // Execution time per instruction; everything else takes the short time
  function [20:0] clif_exec_cycles;
    input [3:0] c;
    begin
      case (c)
        `CLIF_BIT_CLEAR:
          clif_exec_cycles = CYC_CLEAR_W;
        `CLIF_BIT_HOME:
          clif_exec_cycles = CYC_HOME_W;
        default:
          clif_exec_cycles = CYC_SHORT_W;
      endcase
    end
  endfunction

  clif_timer u_timer
  (
    .pclk(pclk),
    .presetn(presetn),
    .start(tstart),
    .cycles(tcyc),
    .busy(busy_flag),
    .done_q()
  );

  // Zero wait states; every request completes in its first access cycle
  assign pready = 1'b1;
  assign acc = psel && penable;
  assign mapped = is_instr || is_data || is_stat;
  assign pslverr = acc && !mapped;
  assign wr_acc = acc && pwrite && mapped;
  assign rd_acc = acc && !pwrite && mapped;
  // Two host registers; select plus direction plus byte
  assign is_instr = (paddr == ADDR_INSTR);
  assign is_data = (paddr == ADDR_DATA);
  // Status word is an extra read-only view, never refused
  assign is_stat = (paddr == ADDR_STAT);
  // Launch only from an idle front end with the timer stopped
  assign launch_ok = (state_q == ST_IDLE) && !busy_flag && (is_instr || is_data) && acc;
  // Busy, blanking or a pending counter step refuse the request
  assign refuse_now = (busy_flag || state_q != ST_IDLE) && acc && (is_data || (is_instr && pwrite));
  // RAM writes only for accepted data writes
  assign dd_we = tstart && is_data && wr_acc && !cg_sel_q;
  assign cg_we = tstart && is_data && wr_acc && cg_sel_q;

  // Instruction launch and execution time choice
  always @*
  begin
    cmd = clif_decode(pwdata[7:0]);
    tstart = 1'b0;
    tcyc = CYC_SHORT_W;
    // Busy refuses everything but status and instruction register reads
    if (launch_ok)
    begin
      if (is_instr && pwrite)
      begin
        tstart = 1'b1;
        tcyc = clif_exec_cycles(cmd);
      end
      else if (is_data)
        tstart = 1'b1;
    end
  end

  // Read data from flip-flop-free mux; status read is never refused
  always @*
  begin
    prdata = 32'h00000000;
    if (rd_acc)
    begin
      if (is_instr)
        prdata = {24'h000000, busy_flag, addr_q};
      else if (is_data)
        prdata = {24'h000000, cg_sel_q ? cg_mem[addr_q[5:0]] : dd_mem[addr_q]};
      else
        prdata = {30'h00000000, refused_q, busy_flag};
    end
  end

  // No reset on the RAMs; only clear display blanks the display RAM
  always @(posedge pclk)
  begin
    if (state_q == ST_CLEAR)
      dd_mem[clr_idx_q] <= `CLIF_SPACE_CODE;
    else if (dd_we)
      dd_mem[addr_q] <= pwdata[7:0];
  end

  always @(posedge pclk)
  begin
    if (cg_we)
      cg_mem[addr_q[5:0]] <= pwdata[7:0];
  end

  // Sticky refusal record; a status read clears it, a new refusal wins
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      refused_q <= 1'b0;
    else if (refuse_now)
      refused_q <= 1'b1;
    else if (rd_acc && is_stat)
      refused_q <= 1'b0;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ST_IDLE;
      addr_q <= 7'h00;
      cg_sel_q <= 1'b0;
      inc_q <= `CLIF_RST_ENTRY_INC;
      shift_q <= `CLIF_RST_ENTRY_SHIFT;
      pend_step_q <= 1'b0;
      pend_shift_q <= 1'b0;
      clr_idx_q <= 7'h00;
      display_shift_q <= 7'h00;
      display_on_q <= 1'b0;
      cursor_on_q <= 1'b0;
      blink_on_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (tstart)
          begin
            state_q <= ST_EXEC;
            if (is_data)
            begin
              pend_step_q <= 1'b1;
              // Shift rides on writes to display RAM only
              pend_shift_q <= pwrite && shift_q && !cg_sel_q;
            end
            else
            begin
              case (cmd)
                `CLIF_BIT_CLEAR:
                begin
                  addr_q <= 7'h00;
                  cg_sel_q <= 1'b0;
                  inc_q <= 1'b1;
                  display_shift_q <= 7'h00;
                  clr_idx_q <= 7'h00;
                  state_q <= ST_CLEAR;
                end
                `CLIF_BIT_HOME:
                begin
                  addr_q <= 7'h00;
                  cg_sel_q <= 1'b0;
                  display_shift_q <= 7'h00;
                end
                `CLIF_BIT_ENTRY:
                begin
                  inc_q <= pwdata[1];
                  shift_q <= pwdata[0];
                end
                `CLIF_BIT_DISP:
                begin
                  display_on_q <= pwdata[2];
                  cursor_on_q <= pwdata[1];
                  blink_on_q <= pwdata[0];
                end
                `CLIF_BIT_SHIFT:
                begin
                  if (pwdata[3])
                    display_shift_q <= pwdata[2] ? display_shift_q + 7'h01 : display_shift_q - 7'h01;
                  else
                    addr_q <= clif_step(addr_q, pwdata[2], cg_sel_q);
                end
                `CLIF_BIT_CGADR:
                begin
                  addr_q <= {1'b0, pwdata[5:0]};
                  cg_sel_q <= 1'b1;
                end
                `CLIF_BIT_DDADR:
                begin
                  addr_q <= pwdata[6:0];
                  cg_sel_q <= 1'b0;
                end
                default:
                  cg_sel_q <= cg_sel_q;
              endcase
            end
          end
        end
        ST_CLEAR:
        begin
          // Blanking runs under busy; it ends well inside the clear time
          clr_idx_q <= clr_idx_q + 7'h01;
          if (clr_idx_q == 7'h7F)
            state_q <= ST_EXEC;
        end
        ST_EXEC:
        begin
          // Counter moves only after busy falls
          if (!busy_flag)
            state_q <= pend_step_q ? ST_ADD : ST_IDLE;
        end
        ST_ADD:
        begin
          addr_q <= clif_step(addr_q, inc_q, cg_sel_q);
          if (pend_shift_q)
            display_shift_q <= inc_q ? display_shift_q - 7'h01 : display_shift_q + 7'h01;
          pend_step_q <= 1'b0;
          pend_shift_q <= 1'b0;
          state_q <= ST_IDLE;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end
endmodule // clif_frontend

/* clif_host.sv */
// Host bus master model
`timescale 1ns/1ps
module clif_host
(
  input wire pclk,
  input wire pready,
  input wire [31:0] prdata,
  output reg psel = 1'b0,
  output reg penable = 1'b0,
  output reg pwrite = 1'b0,
  output reg [11:0] paddr = 12'h000,
  output reg [31:0] pwdata = 32'h0
);
  // Select, direction and byte travel together as one instruction
  task xfer(input reg w, input reg [11:0] a, input reg [31:0] d, output reg [31:0] q);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      // Stale data must not look valid
      pwdata <= ~d;
    end
  endtask
endmodule // clif_host

/* clif_timer.v */
// Execution timer holding the busy flag
`timescale 1ns/1ps
module clif_timer
(
  input wire pclk,
  input wire presetn,
  input wire start,
  input wire [20:0] cycles,
  output wire busy,
  output reg done_q
);
  reg [20:0] count_q;
  assign busy = (count_q != 21'h000000);
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_q <= 21'h000000;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= (count_q == 21'h000001);
      if (start)
        count_q <= cycles;
      else if (busy)
        count_q <= count_q - 21'h000001;
    end
  end
endmodule // clif_timer

/* tb_clif_frontend.sv */
// Self-checking bench for the instruction front end
`timescale 1ns/1ps
module tb_clif_frontend;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  wire psel, penable, pwrite, pready, pslverr, display_on_q, cursor_on_q, blink_on_q;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  wire [6:0] display_shift_q;
  int failures = 0;
  int check_count = 0;
  reg [31:0] lfsr_q = 32'h98181C3D;
  reg [31:0] q_exp[$];
  reg [31:0] q_msk[$];
  reg [31:0] rv;
  reg [7:0] b [0:2];
  always #50 pclk = ~pclk;
  // Clear kept above the blanking sweep length
  clif_frontend #(.CYC_CLEAR(140), .CYC_HOME(30), .CYC_SHORT(10)) i_clif_frontend (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .display_shift_q(display_shift_q),
    .display_on_q(display_on_q), .cursor_on_q(cursor_on_q), .blink_on_q(blink_on_q));
  clif_host i_clif_host (.pclk(pclk), .pready(pready), .prdata(prdata), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  function automatic [31:0] lfsr_next(input [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task cmp(input string n, input [31:0] e, input [31:0] g, input [31:0] m);
    begin
      check_count++;
      if ((g & m) !== (e & m))
      begin
        failures++;
        $display("MISMATCH %s expected %h seen %h", n, e & m, g & m);
      end
    end
  endtask
  task wr(input [11:0] a, input [7:0] d);
    begin
      lfsr_q = lfsr_next(lfsr_q);
      i_clif_host.xfer(1'b1, a, {lfsr_q[31:8], d}, rv);
    end
  endtask
  task rd(input [11:0] a, input [31:0] e, input [31:0] m);
    begin
      q_exp.push_back(e);
      q_msk.push_back(m);
      i_clif_host.xfer(1'b0, a, lfsr_q, rv);
    end
  endtask
  task settle;
    int n;
    begin
      n = 0;
      do begin rd(12'h000, 32'h0, 32'h0); n++; end while (rv[7] !== 1'b0 && n < 400);
      if (rv[7] !== 1'b0)
      begin
        failures++;
        $display("MISMATCH busy_flag expected 0 seen %b", rv[7]);
      end
      repeat (3) @(posedge pclk);
    end
  endtask
  task done(input string s);
    $display("test %s finished", s);
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  always @(posedge pclk)
    if (psel && penable && !pwrite && pready)
    begin
      if (q_exp.size() == 0)
      begin
        failures++;
        $display("MISMATCH prdata expected none seen %h", prdata);
      end
      else cmp("prdata", q_exp.pop_front(), prdata, q_msk.pop_front());
    end
  initial
  begin
    #(20000 * 100);
    failures++;
    tally_and_finish;
  end
  initial
  begin
    for (int i = 0; i < 3; i++)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      b[i] = lfsr_q[15:8];
    end
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000, 32'h0, 32'hFF);
    wr(12'h000, 8'h06);
    rd(12'h000, 32'h80, 32'h80);
    settle;
    wr(12'h004, b[0]);
    wr(12'h004, b[1]);
    rd(12'h008, 32'h2, 32'h2);
    settle;
    rd(12'h000, 32'h01, 32'hFF);
    wr(12'h004, b[1]);
    settle;
    rd(12'h000, 32'h02, 32'hFF);
    done("increment");
    wr(12'h000, 8'h04);
    settle;
    wr(12'h004, b[2]);
    settle;
    rd(12'h000, 32'h01, 32'hFF);
    wr(12'h000, 8'h03);
    settle;
    rd(12'h000, 32'h00, 32'hFF);
    rd(12'h004, {24'h0, b[0]}, 32'hFF);
    settle;
    rd(12'h000, 32'h7F, 32'hFF);
    done("home");
    wr(12'h000, 8'h07);
    settle;
    wr(12'h004, b[1]);
    settle;
    cmp("display_shift_q", 32'h7F, {25'h0, display_shift_q}, 32'h7F);
    wr(12'h000, 8'h04);
    settle;
    wr(12'h000, 8'h01);
    rd(12'h000, 32'h80, 32'h80);
    settle;
    rd(12'h000, 32'h00, 32'hFF);
    cmp("display_shift_q", 32'h0, {25'h0, display_shift_q}, 32'h7F);
    rd(12'h004, 32'h20, 32'hFF);
    settle;
    rd(12'h000, 32'h01, 32'hFF);
    rd(12'h00C, 32'h0, 32'hFFFFFFFF);
    done("clear");
    wr(12'h000, 8'h0D);
    repeat (40) @(posedge pclk);
    cmp("display_ctrl", 32'h5, {29'h0, display_on_q, cursor_on_q, blink_on_q}, 32'h7);
    wr(12'h000, 8'h1C);
    settle;
    cmp("display_shift_q", 32'h01, {25'h0, display_shift_q}, 32'h7F);
    wr(12'h000, 8'h14);
    settle;
    rd(12'h000, 32'h02, 32'hFF);
    wr(12'h000, 8'hC5);
    settle;
    rd(12'h000, 32'h45, 32'hFF);
    wr(12'h000, 8'h48);
    settle;
    wr(12'h004, b[2]);
    settle;
    rd(12'h000, 32'h09, 32'hFF);
    wr(12'h000, 8'h48);
    settle;
    rd(12'h004, {24'h0, b[2]}, 32'hFF);
    settle;
    rd(12'h000, 32'h09, 32'hFF);
    wr(12'h000, 8'h7F);
    settle;
    wr(12'h004, b[0]);
    settle;
    rd(12'h000, 32'h00, 32'hFF);
    done("control");
    repeat (2) @(posedge pclk);
    tally_and_finish;
  end
endmodule // tb_clif_frontend
bind clif_frontend clif_checker i_clif_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .display_shift_q(display_shift_q), .display_on_q(display_on_q),
  .cursor_on_q(cursor_on_q), .blink_on_q(blink_on_q));
